// file: hdl/cao_exec.sv
// Execution unit for compare, block search and accumulator adjust operations
//
// Summary of operation
// - Flip carry; old carry to half, clear subtract
// - Flip carry and invert take four T
// - Field codes 000-101 pick B-L, 111 accumulator
// - Compare subtracts operand, keeps only flags
// - Compare flags from difference, borrow and overflow
// - Indexed compare 19 T; register 4; others 7
// - Downward search compares, then pointer and counter decrement
// - Upward search compares, pointer up, counter down
// - Search flags: match zero, counter nonzero, carry kept
// - Searches leave accumulator and memory untouched
// - Single or final search step takes 16 T
// - Repeat stops on zero count or match
// - Zero start count wraps through 64K bytes
// - Interrupts accepted between iterations; two refreshes each
// - Continuing repeat iteration takes 21 T
// - Invert accumulator, set half and subtract
// - Decimal adjust corrects accumulator to packed BCD
// - Adjust sets sign, zero, parity; subtract kept
// - Index decrement subtracts one from index one
// - Index decrement takes 10 T, flags kept
`timescale 1ns/1ns
module cao_exec
    import cao_pkg::*;
#(
    parameter int TDIV = cao_pkg::T_STATE_CYCLES
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start,
    input wire cao_pkg::cao_op_type op,
    input wire logic [2:0] reg_sel,
    input wire logic [7:0] reg_d,
    input wire logic [7:0] reg_e,
    input wire logic ld_en,
    input wire cao_pkg::cao_ld_type ld_sel,
    input wire logic [15:0] ld_data,
    input wire logic int_pending,
    input wire logic [7:0] mem_rdata,
    output logic busy,
    output logic done,
    output logic mem_rd,
    output logic [15:0] mem_addr,
    output logic refresh,
    output logic int_ack,
    output logic [7:0] acc,
    output logic [7:0] flags,
    output logic [15:0] pointer_pair,
    output logic [15:0] byte_counter_pair,
    output logic [15:0] index_register_one,
    output logic [15:0] pc
);
    typedef enum logic {ST_IDLE, ST_RUN} cao_state_type;

    cao_state_type st_q, st_d;
    cao_op_type op_q, op_d;
    logic [2:0] sel_q, sel_d;
    logic [4:0] t_q, t_d;
    logic [7:0] acc_q, acc_d, flags_q, flags_d, disp_q, disp_d;
    logic [15:0] ptr_q, ptr_d, cnt_q, cnt_d, idx_q, idx_d, pc_q, pc_d, addr_q, addr_d;
    logic rd_q, rd_d, rfsh_q, rfsh_d, done_q, done_d, iack_q, iack_d;
    logic [7:0] div_q, div_d;
    logic t_en;
    logic [7:0] cmp_b, cmp_diff;
    logic cmp_half, cmp_ovf, cmp_borrow;
    logic [9:0] adj;
    logic rpt_go;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Register field decode
    function automatic logic [7:0] reg_pick(input logic [2:0] sel, input logic [15:0] cnt,
        input logic [7:0] d, input logic [7:0] e, input logic [15:0] ptr, input logic [7:0] a);
        logic [7:0] v;
        unique case (sel)
            SEL_B: v = cnt[15:8];
            SEL_C: v = cnt[7:0];
            SEL_D: v = d;
            SEL_E: v = e;
            SEL_H: v = ptr[15:8];
            SEL_L: v = ptr[7:0];
            SEL_A: v = a;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : reg_pick

    function automatic logic is_search(input cao_op_type o);
        return o inside {CAO_SRCH_UP, CAO_SRCH_DN, CAO_SRCH_UP_RPT, CAO_SRCH_DN_RPT};
    endfunction : is_search

    function automatic logic is_repeat(input cao_op_type o);
        return o inside {CAO_SRCH_UP_RPT, CAO_SRCH_DN_RPT};
    endfunction : is_repeat

    // Last T state of a step that does not continue
    function automatic logic [4:0] t_last(input cao_op_type o);
        logic [4:0] v;
        unique case (o)
            CAO_CMP_IMM, CAO_CMP_PTR: v = T_LAST_MEM;
            CAO_CMP_IDX: v = T_LAST_CMPIDX;
            CAO_IDX_DEC: v = T_LAST_IDXDEC;
            CAO_SRCH_UP, CAO_SRCH_DN, CAO_SRCH_UP_RPT, CAO_SRCH_DN_RPT: v = T_LAST_SRCH;
            default: v = T_LAST_SHORT;
        endcase
        return v;
    endfunction : t_last

    // BCD correction, returns {half, carry, value}
    function automatic logic [9:0] dec_adjust(input logic [7:0] a, input logic [7:0] f);
        logic [7:0] corr;
        logic [7:0] res;
        logic c_out;
        logic h_out;
        corr = 8'h00;
        if (f[FLAG_H] || (a[3:0] > BCD_LO_MAX))
            corr = CORR_LO;
        c_out = f[FLAG_C] || (a > BCD_MAX);
        if (c_out)
            corr = corr | CORR_HI;
        if (f[FLAG_N])
        begin
            h_out = f[FLAG_H] && (a[3:0] < LO_SUB_LIMIT);
            res = a - corr;
        end
        else
        begin
            h_out = (a[3:0] > BCD_LO_MAX);
            res = a + corr;
        end
        return {h_out, c_out, res};
    endfunction : dec_adjust

    // ------------------------------------------------------------
    // T-state divider
    // ------------------------------------------------------------
    // Restarted by a start so every op begins on a whole T state
    always_comb
    begin
        t_en = (div_q == 8'(TDIV - 1));
        if ((st_q == ST_IDLE && start) || t_en)
            div_d = 8'h00;
        else
            div_d = div_q + 8'h01;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            div_q <= 8'h00;
        else
            div_q <= div_d;
    end

    // ------------------------------------------------------------
    // Shared subtractor
    // ------------------------------------------------------------
    // One subtractor; its difference is never stored
    assign cmp_b = (op_q == CAO_CMP_REG) ? reg_pick(sel_q, cnt_q, reg_d, reg_e, ptr_q, acc_q)
                                         : mem_rdata;

    cao_sub8 u_sub
    (
        .minuend(acc_q),
        .subtrahend(cmp_b),
        .diff(cmp_diff),
        .half_borrow(cmp_half),
        .overflow(cmp_ovf),
        .borrow(cmp_borrow)
    );

    assign adj = dec_adjust(acc_q, flags_q);
    // Continue only while count nonzero and no match
    assign rpt_go = is_repeat(op_q) && flags_q[FLAG_PV] && !flags_q[FLAG_Z];

    // ------------------------------------------------------------
    // Sequencer and datapath
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        op_d = op_q;
        sel_d = sel_q;
        t_d = t_q;
        acc_d = acc_q;
        flags_d = flags_q;
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        pc_d = pc_q;
        disp_d = disp_q;
        addr_d = addr_q;
        rd_d = 1'b0;
        rfsh_d = 1'b0;
        done_d = 1'b0;
        iack_d = 1'b0;
        unique case (st_q)
            ST_IDLE:
            begin
                // Loads only while idle, so a step never sees a torn value
                if (ld_en)
                begin
                    unique case (ld_sel)
                        CAO_LD_ACC: acc_d = ld_data[7:0];
                        CAO_LD_FLAGS: flags_d = ld_data[7:0];
                        CAO_LD_PTR: ptr_d = ld_data;
                        CAO_LD_CNT: cnt_d = ld_data;
                        CAO_LD_IDX: idx_d = ld_data;
                        CAO_LD_PC: pc_d = ld_data;
                        default: acc_d = acc_q;
                    endcase
                end
                if (start)
                begin
                    st_d = ST_RUN;
                    op_d = op;
                    sel_d = reg_sel;
                    t_d = T_ZERO;
                end
            end
            ST_RUN:
            begin
                if (t_en)
                begin
                    t_d = t_q + T_ONE;
                    if ((op_q == CAO_CMP_REG && t_q == T_LAST_SHORT)
                        || (op_q inside {CAO_CMP_IMM, CAO_CMP_PTR} && t_q == T_SMP_M2)
                        || (op_q == CAO_CMP_IDX && t_q == T_SMP_M5))
                    begin
                        flags_d[FLAG_S] = cmp_diff[7];
                        flags_d[FLAG_Z] = (cmp_diff == 8'h00);
                        flags_d[FLAG_H] = cmp_half;
                        flags_d[FLAG_PV] = cmp_ovf;
                        flags_d[FLAG_N] = 1'b1;
                        flags_d[FLAG_C] = cmp_borrow;
                        if (op_q == CAO_CMP_IMM)
                            pc_d = pc_q + WORD_ONE;
                    end
                    // Displacement byte of an indexed compare
                    if (op_q == CAO_CMP_IDX && t_q == T_SMP_M3)
                    begin
                        disp_d = mem_rdata;
                        pc_d = pc_q + WORD_ONE;
                    end
                    if (is_search(op_q) && t_q == T_SMP_M3)
                    begin
                        flags_d[FLAG_S] = cmp_diff[7];
                        flags_d[FLAG_Z] = (cmp_diff == 8'h00);
                        flags_d[FLAG_H] = cmp_half;
                        flags_d[FLAG_PV] = (cnt_q != WORD_ONE);
                        flags_d[FLAG_N] = 1'b1;
                        cnt_d = cnt_q - WORD_ONE;
                        if (op_q inside {CAO_SRCH_UP, CAO_SRCH_UP_RPT})
                            ptr_d = ptr_q + WORD_ONE;
                        else
                            ptr_d = ptr_q - WORD_ONE;
                    end
                    // Step ends at its last T
                    if (t_q == t_last(op_q) && !(is_search(op_q) && rpt_go))
                    begin
                        st_d = ST_IDLE;
                        done_d = 1'b1;
                        unique case (op_q)
                            CAO_FLIP_CARRY:
                            begin
                                flags_d[FLAG_H] = flags_q[FLAG_C];
                                flags_d[FLAG_C] = !flags_q[FLAG_C];
                                flags_d[FLAG_N] = 1'b0;
                            end
                            CAO_INVERT_ACC:
                            begin
                                acc_d = ~acc_q;
                                flags_d[FLAG_H] = 1'b1;
                                flags_d[FLAG_N] = 1'b1;
                            end
                            CAO_DEC_ADJUST:
                            begin
                                acc_d = adj[7:0];
                                flags_d[FLAG_S] = adj[7];
                                flags_d[FLAG_Z] = (adj[7:0] == 8'h00);
                                flags_d[FLAG_PV] = ~^adj[7:0];
                                flags_d[FLAG_H] = adj[9];
                                flags_d[FLAG_C] = adj[8];
                            end
                            CAO_IDX_DEC: idx_d = idx_q - WORD_ONE;
                            default: acc_d = acc_q;
                        endcase
                    end
                    // Rewind, then restart or take interrupt
                    if (t_q == T_LAST_RPT)
                    begin
                        pc_d = pc_q - PC_REWIND;
                        t_d = T_ZERO;
                        if (int_pending)
                        begin
                            st_d = ST_IDLE;
                            done_d = 1'b1;
                            iack_d = 1'b1;
                        end
                    end
                    // Memory reads and refresh, issued at the start of their cycle
                    if (st_d == ST_RUN)
                    begin
                        if ((op_q inside {CAO_CMP_IMM, CAO_CMP_PTR} && t_d == T_RD_M2)
                            || ((is_search(op_q) || op_q == CAO_CMP_IDX) && t_d == T_RD_M3)
                            || (op_q == CAO_CMP_IDX && t_d == T_RD_M5))
                            rd_d = 1'b1;
                        if (op_q == CAO_CMP_IMM || (op_q == CAO_CMP_IDX && t_d == T_RD_M3))
                            addr_d = pc_d;
                        else if (op_q == CAO_CMP_IDX)
                            addr_d = idx_q + {{8{disp_d[7]}}, disp_d};
                        else
                            addr_d = ptr_d;
                        // Two refresh cycles after each search comparison that continues the repeat
                        rfsh_d = is_search(op_q) && (t_d == T_RFSH_A || t_d == T_RFSH_B);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q <= ST_IDLE;
            op_q <= CAO_FLIP_CARRY;
            sel_q <= SEL_B;
            t_q <= T_ZERO;
            acc_q <= 8'h00;
            flags_q <= FLAGS_RESET;
            ptr_q <= 16'h0000;
            cnt_q <= 16'h0000;
            idx_q <= 16'h0000;
            pc_q <= 16'h0000;
            disp_q <= 8'h00;
            addr_q <= 16'h0000;
            rd_q <= 1'b0;
            rfsh_q <= 1'b0;
            done_q <= 1'b0;
            iack_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            op_q <= op_d;
            sel_q <= sel_d;
            t_q <= t_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            pc_q <= pc_d;
            disp_q <= disp_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            rfsh_q <= rfsh_d;
            done_q <= done_d;
            iack_q <= iack_d;
        end
    end

    // Outputs, all from flip-flops except busy
    assign busy = (st_q == ST_RUN);
    assign done = done_q;
    assign mem_rd = rd_q;
    assign mem_addr = addr_q;
    assign refresh = rfsh_q;
    assign int_ack = iack_q;
    assign acc = acc_q;
    assign flags = flags_q;
    assign pointer_pair = ptr_q;
    assign byte_counter_pair = cnt_q;
    assign index_register_one = idx_q;
    assign pc = pc_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Clocks since the step began; only the assertions read it
    logic [7:0] cyc_q;
    always_ff @(posedge mclk)
    begin
        if (sys_rst || st_q == ST_IDLE || (t_en && t_q == T_LAST_RPT))
            cyc_q <= 8'h00;
        else
            cyc_q <= cyc_q + 8'h01;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_two_rfsh;
        ##[1:64] refresh ##[1:64] refresh;
    endsequence

    a_flip_carry: assert property (done_q && op_q == CAO_FLIP_CARRY && !iack_q
        |-> flags_q[FLAG_H] == !flags_q[FLAG_C] && !flags_q[FLAG_N])
        else $error("carry flip flags wrong");
    a_short_len: assert property (st_q == ST_RUN && t_en
        && op_q inside {CAO_FLIP_CARRY, CAO_INVERT_ACC} |-> t_q <= T_LAST_SHORT
        && cyc_q == 8'((int'(t_q) + 1) * TDIV - 1))
        else $error("short op length wrong");
    a_cmp_flags: assert property (st_q == ST_RUN && t_en && op_q == CAO_CMP_REG
        && t_q == T_LAST_SHORT |=> flags_q[FLAG_C] == $past(cmp_borrow)
        && flags_q[FLAG_N] && $stable(acc_q))
        else $error("compare flags wrong");
    a_idx_cmp_len: assert property (done_q && $past(op_q) == CAO_CMP_IDX
        |-> $past(t_q) == T_LAST_CMPIDX)
        else $error("indexed compare length wrong");
    a_search_flags: assert property (st_q == ST_RUN && t_en && is_search(op_q)
        && t_q == T_SMP_M3 |=> flags_q[FLAG_Z] == ($past(acc_q) == $past(mem_rdata))
        && flags_q[FLAG_PV] == ($past(cnt_q) != WORD_ONE)
        && flags_q[FLAG_C] == $past(flags_q[FLAG_C]) && cnt_q == $past(cnt_q) - WORD_ONE)
        else $error("search step flags wrong");
    a_search_keep: assert property (st_q == ST_RUN && is_search(op_q)
        |=> $stable(acc_q))
        else $error("search changed accumulator");
    a_pc_rewind: assert property (st_q == ST_RUN && t_en && t_q == T_LAST_RPT
        |=> pc_q == $past(pc_q) - PC_REWIND)
        else $error("repeat did not rewind pc");
    a_two_refresh: assert property (st_q == ST_RUN && t_en && t_q == T_LAST_SRCH
        && is_search(op_q) && rpt_go |-> s_two_rfsh)
        else $error("refresh cycles missing");
    a_rpt_len: assert property (st_q == ST_RUN && t_en && t_q == T_LAST_RPT
        |-> cyc_q == 8'((int'(T_LAST_RPT) + 1) * TDIV - 1))
        else $error("repeat iteration length wrong");
    a_invert_acc: assert property (st_q == ST_RUN && t_en
        && op_q == CAO_INVERT_ACC && t_q == T_LAST_SHORT
        |=> acc_q == ~$past(acc_q) && flags_q[FLAG_H] && flags_q[FLAG_N])
        else $error("invert result wrong");
    a_idx_dec: assert property (st_q == ST_RUN && t_en
        && op_q == CAO_IDX_DEC && t_q == T_LAST_IDXDEC
        |=> idx_q == $past(idx_q) - WORD_ONE && $stable(flags_q) && done_q)
        else $error("index decrement wrong");

endmodule : cao_exec

// file: hdl/cao_sub8.sv
// Eight-bit subtractor shared by compare and block search
`timescale 1ns/1ns
module cao_sub8
(
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    output logic [7:0] diff,
    output logic half_borrow,
    output logic overflow,
    output logic borrow
);
    logic [8:0] wide;

    // Difference, borrow out of bits 3 and 7, and signed overflow
    always_comb
    begin
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        diff = wide[7:0];
        borrow = wide[8];
        half_borrow = (minuend[3:0] < subtrahend[3:0]);
        overflow = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide[7]);
    end

endmodule : cao_sub8

// file: pkg/cao_pkg.sv
// Shared constants and types for the compare and accumulator execution unit
package cao_pkg;

    // ------------------------------------------------------------
    // Operation and load selection
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CAO_FLIP_CARRY,
        CAO_CMP_REG,
        CAO_CMP_IMM,
        CAO_CMP_PTR,
        CAO_CMP_IDX,
        CAO_SRCH_UP,
        CAO_SRCH_DN,
        CAO_SRCH_UP_RPT,
        CAO_SRCH_DN_RPT,
        CAO_INVERT_ACC,
        CAO_DEC_ADJUST,
        CAO_IDX_DEC
    } cao_op_type;

    typedef enum logic [2:0] {
        CAO_LD_ACC,
        CAO_LD_FLAGS,
        CAO_LD_PTR,
        CAO_LD_CNT,
        CAO_LD_IDX,
        CAO_LD_PC
    } cao_ld_type;

    // ------------------------------------------------------------
    // Flag bit positions
    // ------------------------------------------------------------
    localparam int FLAG_S = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_H = 4;
    localparam int FLAG_PV = 2;
    localparam int FLAG_N = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ------------------------------------------------------------
    // Register field codes of a compare
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_B = 3'h0;
    localparam logic [2:0] SEL_C = 3'h1;
    localparam logic [2:0] SEL_D = 3'h2;
    localparam logic [2:0] SEL_E = 3'h3;
    localparam logic [2:0] SEL_H = 3'h4;
    localparam logic [2:0] SEL_L = 3'h5;
    localparam logic [2:0] SEL_A = 3'h7;

    // ------------------------------------------------------------
    // Timing: one T state per clock enable, indices count from zero
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_STATE_NS = 40;
    localparam int T_STATE_CYCLES = (T_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] T_ZERO = 5'h00;
    localparam logic [4:0] T_ONE = 5'h01;
    localparam logic [4:0] T_LAST_SHORT = 5'h03;
    localparam logic [4:0] T_LAST_MEM = 5'h06;
    localparam logic [4:0] T_LAST_IDXDEC = 5'h09;
    localparam logic [4:0] T_LAST_SRCH = 5'h0F;
    localparam logic [4:0] T_LAST_CMPIDX = 5'h12;
    localparam logic [4:0] T_LAST_RPT = 5'h14;
    localparam logic [4:0] T_RD_M2 = 5'h04;
    localparam logic [4:0] T_SMP_M2 = 5'h06;
    localparam logic [4:0] T_RD_M3 = 5'h08;
    localparam logic [4:0] T_SMP_M3 = 5'h0A;
    localparam logic [4:0] T_RD_M5 = 5'h10;
    localparam logic [4:0] T_SMP_M5 = 5'h12;
    localparam logic [4:0] T_RFSH_A = 5'h10;
    localparam logic [4:0] T_RFSH_B = 5'h12;

    // ------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [15:0] PC_REWIND = 16'h0002;
    localparam logic [3:0] BCD_LO_MAX = 4'h9;
    localparam logic [3:0] LO_SUB_LIMIT = 4'h6;
    localparam logic [7:0] BCD_MAX = 8'h99;
    localparam logic [7:0] CORR_LO = 8'h06;
    localparam logic [7:0] CORR_HI = 8'h60;

endpackage : cao_pkg

// file: testbench/cao_exec_tb_top.sv
// Self-checking bench for the compare and accumulator unit
`timescale 1ns/1ns
module cao_exec_tb_top;
    import cao_pkg::*;
    logic mclk = 0, sys_rst = 1, start = 0, ld_en = 0, ip = 0;
    logic [2:0] reg_sel = 0;
    logic [7:0] reg_d = 0, reg_e = 0, mem_rdata, acc, flags, a, f, b;
    logic [7:0] rv [8];
    logic [15:0] ld_data = 0, ptr, cnt, idx, pc, m_ptr, m_cnt, m_idx, m_pc, r0, rf = 0;
    logic busy, done, mem_rd, refresh, int_ack;
    logic [15:0] mem_addr;
    cao_op_type op = CAO_FLIP_CARRY;
    cao_ld_type ld_sel = CAO_LD_ACC;
    int err_count = 0, compares = 0, seed = 91601, n, en, k, i, g;
    always #20 mclk = ~mclk;
    // Refresh pulses are counted for the repeat checks
    always @(posedge mclk) rf <= refresh ? rf + 16'h0001 : rf;
    cao_exec u_cao_exec (.mclk(mclk), .sys_rst(sys_rst), .start(start), .op(op),
        .reg_sel(reg_sel), .reg_d(reg_d), .reg_e(reg_e), .ld_en(ld_en), .ld_sel(ld_sel),
        .ld_data(ld_data), .int_pending(ip), .mem_rdata(mem_rdata), .busy(busy),
        .done(done), .mem_rd(mem_rd), .mem_addr(mem_addr), .refresh(refresh),
        .int_ack(int_ack), .acc(acc), .flags(flags), .pointer_pair(ptr),
        .byte_counter_pair(cnt), .index_register_one(idx), .pc(pc));
    cao_mem_model u_cao_mem_model (.mclk(mclk), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] mb(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5A;
    endfunction : mb
    function automatic logic [7:0] sf(input logic [7:0] x, input logic [7:0] y);
        logic [7:0] d;
        d = x - y;
        return {d[7], d == 0, 1'b0, x[3:0] < y[3:0], 1'b0,
            x[7] != y[7] && d[7] != x[7], 1'b1, x < y};
    endfunction : sf
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic ld(input cao_ld_type s, input logic [15:0] v);
        ld_en = 1;
        ld_sel = s;
        ld_data = v;
        @(negedge mclk);
    endtask : ld
    task automatic close_out();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // Random operations against the reference model
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(negedge mclk);
        sys_rst = 0;
        for (i = 0; i < 120; i++)
        begin
            op = cao_op_type'(i % 12);
            {a, f} = $random(seed);
            {m_ptr, m_idx} = $random(seed);
            {m_pc, reg_d, reg_e} = {$random(seed), $random(seed)};
            // Small counts keep repeats short; a zero count wraps, so a match is planted
            m_cnt = {13'h0000, i[5:3]};
            reg_sel = i[5:3];
            ip = $random(seed) % 4 == 0;
            a = (i % 3 == 0 || m_cnt == 0) ? mb(op[0] ? m_ptr + 16'h0002 : m_ptr - 16'h0002) : a;
            ld(CAO_LD_ACC, {8'h00, a});
            ld(CAO_LD_FLAGS, {8'h00, f});
            ld(CAO_LD_PTR, m_ptr);
            ld(CAO_LD_CNT, m_cnt);
            ld(CAO_LD_IDX, m_idx);
            ld(CAO_LD_PC, m_pc);
            rv = '{m_cnt[15:8], m_cnt[7:0], reg_d, reg_e, m_ptr[15:8], m_ptr[7:0], 8'h00, a};
            k = 1;
            g = 0;
            en = 4;
            case (op)
                CAO_FLIP_CARRY: f = {f[7:5], f[0], f[3:2], 1'b0, ~f[0]};
                CAO_INVERT_ACC: {a, f} = {~a, f | 8'h12};
                CAO_CMP_REG: b = rv[reg_sel];
                CAO_CMP_IMM: {b, m_pc, en} = {mb(m_pc), m_pc + 16'h0001, 32'd7};
                CAO_CMP_PTR: {b, en} = {mb(m_ptr), 32'd7};
                CAO_IDX_DEC: {m_idx, en} = {m_idx - 16'h0001, 32'd10};
                CAO_CMP_IDX:
                begin
                    b = mb(m_pc);
                    {b, m_pc, en} = {mb(m_idx + {{8{b[7]}}, b}), m_pc + 16'h0001, 32'd19};
                end
                CAO_DEC_ADJUST:
                begin
                    b = ((a[3:0] > 9 || f[4]) ? 8'h06 : 8'h00) | ((a > 8'h99 || f[0]) ? 8'h60 : 8'h00);
                    f[0] = f[0] || a > 8'h99;
                    f[4] = f[1] ? f[4] && a[3:0] < 6 : a[3:0] > 9;
                    a = f[1] ? a - b : a + b;
                    {f[7:6], f[2]} = {a[7], a == 0, ~^a};
                end
                // Repeat ends on zero count or match
                default:
                begin
                    k = 0;
                    do
                    begin
                        b = mb(m_ptr);
                        f = (sf(a, b) & 8'hFE) | (f & 8'h01);
                        m_ptr = op[0] ? m_ptr + 16'h0001 : m_ptr - 16'h0001;
                        m_cnt = m_cnt - 16'h0001;
                        f[2] = m_cnt != 0;
                        k++;
                        g = op > CAO_SRCH_DN && m_cnt != 0 && a != b;
                    end
                    // Pending interrupt leaves after a continuing pass
                    while (g && !ip);
                    en = 21 * k - (g ? 0 : 5);
                end
            endcase
            f = (op >= CAO_CMP_REG && op <= CAO_CMP_IDX) ? sf(a, b) : f;
            m_pc = m_pc - 16'(2 * (k + g) - 2);
            r0 = rf;
            ld_en = 0;
            start = 1;
            @(negedge mclk);
            start = 0;
            // Bounded wait for completion
            for (n = 0; done !== 1'b1 && n < 400; n++) @(negedge mclk);
            if (done !== 1'b1)
            begin
                err_count++;
                break;
            end
            chk(n[15:0], en[15:0]);
            chk({8'h00, acc}, {8'h00, a});
            chk({8'h00, flags & 8'hD7}, {8'h00, f & 8'hD7});
            chk(ptr, m_ptr);
            chk(cnt, m_cnt);
            chk(idx, m_idx);
            chk(pc, m_pc);
            chk(rf - r0, 16'(2 * (k + g) - 2));
            chk({14'h0000, busy, int_ack}, {15'h0000, g[0]});
        end
        close_out();
    end
endmodule : cao_exec_tb_top

// file: testbench/cao_mem_model.sv
// Memory partner: answers reads, then scrambles once hold expires
`timescale 1ns/1ns
module cao_mem_model
(
    input wire logic mclk,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata
);
    logic [7:0] last_q = 8'h00;
    int age_q = 9;
    // Content is a fixed function of the address, known to the bench
    always @(posedge mclk)
    begin
        last_q <= mem_rd ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A) : last_q;
        age_q <= mem_rd ? 0 : age_q + 1;
    end
    // Stale data is inverted so a late sample cannot pass by luck
    assign mem_rdata = (age_q < 4) ? last_q : ~last_q;
endmodule : cao_mem_model
